// *** common/ecsi_params.svh ***
// Offsets, field positions and reset values of the event channel status block.
`ifndef ECSI_PARAMS_SVH
`define ECSI_PARAMS_SVH

`define ECSI_ADDR_W            8
`define ECSI_NUM_CH            6
`define ECSI_OFS_STATE         8'h0c
`define ECSI_OFS_ENCLR         8'h10
`define ECSI_OFS_ENSET         8'h14
`define ECSI_OFS_FLAGS         8'h18
`define ECSI_HI_LSB            8
`define ECSI_LO_LSB            0
`define ECSI_RST_ENABLE        6'h00
`define ECSI_RST_FLAGS         6'h00
`define ECSI_RST_READY         6'h3f
`define ECSI_RST_BUSY          6'h00

`endif

// *** common/ecsi_pkg.sv ***
// Types shared by the event channel status block.
package ecsi_pkg;

    typedef logic [5:0] ecsi_ch_t;

    // Register bus request from software.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ecsi_req_s;

    // Per-channel activity from the channel logic.
    typedef struct packed {
        ecsi_ch_t busy;
        ecsi_ch_t ready;
        ecsi_ch_t event_seen;
        ecsi_ch_t overrun;
        ecsi_ch_t async_path;
    } ecsi_chan_s;

    // Whole state of the block.
    typedef struct packed {
        ecsi_ch_t    evd_en;
        ecsi_ch_t    ovr_en;
        ecsi_ch_t    event_detected;
        ecsi_ch_t    channel_overrun;
        ecsi_ch_t    channel_busy;
        ecsi_ch_t    users_ready;
        logic [31:0] rdata;
        logic        irq;
    } ecsi_state_s;

endpackage

// *** logic/ecsi_event_channel_status_irq.sv ***
// Channel status, interrupt enables and interrupt flags of the event router.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ecsi_params.svh"

// Contract
// - Busy bit per channel set while an event is unhandled, clear when idle.
// - User-ready bit reads one only when all connected users are ready.
// - Unused register bits read zero; software writes zeros there.
// - Writing one to enable-clear disables that source; zero does nothing.
// - Writing one to enable-set enables that source; zero does nothing.
// - Enable-set and enable-clear are two views of one enable set.
// - Event-detected flag sets the cycle after an event passes the channel.
// - Interrupt raised when any flag is set with its enable one.
// - Overrun flag sets the cycle after an overrun condition.
// - Asynchronous-path channels never set event-detected or overrun flags.
// - Writing one to a flag clears it; zero has no effect.
module ecsi_event_channel_status_irq
#(
    parameter int NUM_CH = `ECSI_NUM_CH
)
(
    // Clock and reset.
    input  wire logic                sys_clk_i,
    input  wire logic                sys_rst_i,
    // Register bus.
    input  wire ecsi_pkg::ecsi_req_s bus_req_i,
    output var  logic [31:0]         bus_rdata_o,
    // Channel logic.
    input  wire ecsi_pkg::ecsi_chan_s chan_i,
    // Interrupt request.
    output var  logic                irq_o
);
    import ecsi_pkg::*;

    // The bit maps are fixed at six channels wide.
    if (NUM_CH != `ECSI_NUM_CH)
    begin : g_bad_ch
        $error("NUM_CH must be six");
    end

    ecsi_state_s st_r;
    ecsi_state_s st_nxt;
    ecsi_ch_t    evd_set;
    ecsi_ch_t    ovr_set;
    ecsi_ch_t    wr_hi;
    ecsi_ch_t    wr_lo;
    logic        wr_clr;
    logic        wr_set;
    logic        wr_flg;

    always_comb
    begin
        st_nxt = st_r;
        wr_hi  = bus_req_i.wdata[`ECSI_HI_LSB +: 6];
        wr_lo  = bus_req_i.wdata[`ECSI_LO_LSB +: 6];
        wr_clr = 1'b0;
        wr_set = 1'b0;
        wr_flg = 1'b0;
        if (bus_req_i.wr && bus_req_i.addr == `ECSI_OFS_ENCLR)
        begin
            wr_clr = 1'b1;
        end
        else if (bus_req_i.wr && bus_req_i.addr == `ECSI_OFS_ENSET)
        begin
            wr_set = 1'b1;
        end
        else if (bus_req_i.wr && bus_req_i.addr == `ECSI_OFS_FLAGS)
        begin
            wr_flg = 1'b1;
        end

        st_nxt.channel_busy = chan_i.busy;
        st_nxt.users_ready  = chan_i.ready;

        if (wr_clr)
        begin
            st_nxt.evd_en = st_r.evd_en & ~wr_hi;
            st_nxt.ovr_en = st_r.ovr_en & ~wr_lo;
        end
        if (wr_set)
        begin
            st_nxt.evd_en = st_r.evd_en | wr_hi;
            st_nxt.ovr_en = st_r.ovr_en | wr_lo;
        end

        evd_set = chan_i.event_seen & ~chan_i.async_path;
        ovr_set = chan_i.overrun & ~chan_i.async_path;
        if (wr_flg)
        begin
            st_nxt.event_detected  = st_r.event_detected & ~wr_hi;
            st_nxt.channel_overrun = st_r.channel_overrun & ~wr_lo;
        end
        // A new event in the clearing cycle wins, so nothing is lost.
        // event detected and overrun set
        st_nxt.event_detected = st_nxt.event_detected | evd_set;
        st_nxt.channel_overrun = st_nxt.channel_overrun | ovr_set;

        st_nxt.irq = |{st_nxt.event_detected & st_nxt.evd_en,
                       st_nxt.channel_overrun & st_nxt.ovr_en};

        // Read data stand only in the cycle after the strobe.
        st_nxt.rdata = 32'h0000_0000;
        if (bus_req_i.rd)
        begin
            if (bus_req_i.addr == `ECSI_OFS_STATE)
            begin
                st_nxt.rdata = {18'h0_0000, st_r.channel_busy,
                                2'h0, st_r.users_ready};
            end
            else if (bus_req_i.addr == `ECSI_OFS_ENCLR ||
                     bus_req_i.addr == `ECSI_OFS_ENSET)
            begin
                st_nxt.rdata = {18'h0_0000, st_r.evd_en,
                                2'h0, st_r.ovr_en};
            end
            else if (bus_req_i.addr == `ECSI_OFS_FLAGS)
            begin
                st_nxt.rdata = {18'h0_0000, st_r.event_detected,
                                2'h0, st_r.channel_overrun};
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_r.evd_en          <= `ECSI_RST_ENABLE;
            st_r.ovr_en          <= `ECSI_RST_ENABLE;
            st_r.event_detected  <= `ECSI_RST_FLAGS;
            st_r.channel_overrun <= `ECSI_RST_FLAGS;
            st_r.channel_busy    <= `ECSI_RST_BUSY;
            st_r.users_ready     <= `ECSI_RST_READY;
            st_r.rdata           <= 32'h0000_0000;
            st_r.irq             <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign bus_rdata_o = st_r.rdata;
    assign irq_o       = st_r.irq;

endmodule
`default_nettype wire

// *** testbench/ecsi_properties.sv ***
// Port checker of the event channel status block.
`timescale 1ns/1ps
`default_nettype none
`include "ecsi_params.svh"
module ecsi_properties #(parameter int NUM_CH = 6)
(
    // Clock and reset.
    input wire logic                 sys_clk_i,
    input wire logic                 sys_rst_i,
    // Bus, channels and interrupt.
    input wire ecsi_pkg::ecsi_req_s  bus_req_i,
    input wire logic [31:0]          bus_rdata_o,
    input wire ecsi_pkg::ecsi_chan_s chan_i,
    input wire logic                 irq_o
);
    wire logic hit = |((chan_i.event_seen | chan_i.overrun)
        & ~chan_i.async_path);
    wire logic ones = bus_req_i.wr && bus_req_i.wdata[13:0] == 14'h3f3f;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_en_all;
        ones && bus_req_i.addr == `ECSI_OFS_ENSET;
    endsequence
    a_rsvd_zero: assert property (
        $past(bus_req_i.rd) |-> !(bus_rdata_o & 32'hffffc0c0))
        else $error("reserved bits");
    a_state_read: assert property (
        !$past(sys_rst_i) && $stable(chan_i) && bus_req_i.rd
        && bus_req_i.addr == `ECSI_OFS_STATE |=> bus_rdata_o == {18'h0,
        $past(chan_i.busy), 2'h0, $past(chan_i.ready)}) else $error("status");
    a_en_views: assert property (
        s_en_all ##1 (bus_req_i.rd && bus_req_i.addr == `ECSI_OFS_ENCLR)
        |=> bus_rdata_o[13:0] == 14'h3f3f) else $error("enable views");
    a_en_clear: assert property (
        ones && bus_req_i.addr == `ECSI_OFS_ENCLR |=> !irq_o)
        else $error("enable clear");
    a_flag_clear: assert property (
        ones && bus_req_i.addr == `ECSI_OFS_FLAGS && !hit |=> !irq_o)
        else $error("flag clear");
    a_event_irq: assert property (
        s_en_all ##1 (hit && !bus_req_i.wr) |=> irq_o) else $error("no irq");
    a_irq_cause: assert property (
        $rose(irq_o) |-> $past(hit) || $past(bus_req_i.wr))
        else $error("irq cause");
    a_async_quiet: assert property (
        &chan_i.async_path && !bus_req_i.wr |=> !$rose(irq_o))
        else $error("async flag");
endmodule
bind ecsi_event_channel_status_irq ecsi_properties #(.NUM_CH(NUM_CH)) i_prop (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .bus_req_i(bus_req_i),
    .bus_rdata_o(bus_rdata_o), .chan_i(chan_i), .irq_o(irq_o));
`default_nettype wire

// *** testbench/test_event_channel_status_irq.sv ***
// Self-checking bench of the event channel status block.
`timescale 1ns/1ps
`default_nettype none
`include "ecsi_params.svh"
`define CHK(e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected read exp %h got %h", e, g); end end
module test_event_channel_status_irq;
    logic sys_clk_i = 0, sys_rst_i = 1, irq, rd_d = 0;
    ecsi_pkg::ecsi_req_s req = '0;
    ecsi_pkg::ecsi_chan_s ch = '{ready: 6'h3f, async_path: 6'h3f,
        default: 6'h0};
    logic [31:0] rdata, en = 0, fl = 0, r, a, s = 32'hd690e274;
    logic [32:0] x, q[$];
    int err_count = 0, num_checks = 0, cyc = 0;
    ecsi_event_channel_status_irq i_dut (.sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i), .bus_req_i(req), .bus_rdata_o(rdata),
        .chan_i(ch), .irq_o(irq));
    always #25 sys_clk_i = ~sys_clk_i;
    function logic [31:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s & 32'h3f3f;
    endfunction
    task op(logic w, logic [7:0] ad, logic [31:0] d);
        @(posedge sys_clk_i);
        req <= '{addr: ad, wdata: d, wr: w, rd: !w};
        if (!w)
            q.push_back({|(fl & en), d});
    endtask
    task complete_run();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge sys_clk_i)
    begin
        cyc++;
        rd_d <= req.rd;
        if (rd_d)
        begin
            x = q.pop_front();
            `CHK(x, {irq, rdata})
        end
        if (cyc > 900)
        begin
            err_count++;
            complete_run();
        end
    end
    initial
    begin
        repeat (3) @(posedge sys_clk_i);
        sys_rst_i <= 0;
        for (int i = 0; i < 5; i++)
            op(0, 8'h0c + 8'(4 * i), i ? 32'h0 : 32'h3f);
        repeat (8)
        begin
            r = rnd();
            op(1, `ECSI_OFS_ENSET, r);
            en |= r;
            op(0, `ECSI_OFS_ENCLR, en);
            r = rnd();
            op(1, `ECSI_OFS_ENCLR, r);
            en &= ~r;
            op(0, `ECSI_OFS_ENSET, en);
            op(1, `ECSI_OFS_ENSET, 32'h3f3f);
            en = 32'h3f3f;
            r = rnd();
            a = rnd();
            @(posedge sys_clk_i);
            req.wr <= 0;
            ch <= '{r[13:8], r[5:0], r[13:8], r[5:0], a[5:0]};
            fl |= r & ~{18'h0, a[5:0], 2'h0, a[5:0]};
            @(posedge sys_clk_i);
            ch.event_seen <= 6'h0;
            ch.overrun <= 6'h0;
            ch.async_path <= 6'h3f;
            op(0, `ECSI_OFS_FLAGS, fl);
            op(0, `ECSI_OFS_STATE, r);
            r = rnd();
            op(1, `ECSI_OFS_FLAGS, r);
            fl &= ~r;
            op(0, `ECSI_OFS_FLAGS, fl);
        end
        op(1, `ECSI_OFS_ENSET, 32'h3f3f);
        en = 32'h3f3f;
        op(0, `ECSI_OFS_ENCLR, en);
        op(1, `ECSI_OFS_FLAGS, 32'h3f3f);
        op(1, `ECSI_OFS_ENCLR, 32'h3f3f);
        @(posedge sys_clk_i);
        req.wr <= 0;
        repeat (3) @(posedge sys_clk_i);
        complete_run();
    end
endmodule
`default_nettype wire
